// file: logic/breakpoint_match.sv
`timescale 1ns/1ns
`default_nettype none
`include "debug_consts.svh"
module breakpoint_match
  import debug_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        enable,
  input  wire logic        force_sel,
  input  wire logic [15:0] match_addr,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_addr_valid,
  input  wire logic        cpu_opcode_fetch,
  output logic             force_req,
  output logic             tag_req
);
  logic hit;
  assign hit = enable && cpu_addr_valid && (cpu_addr == match_addr);

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      force_req <= 1'b0;
      tag_req   <= 1'b0;
    end
    else
    begin
      force_req <= hit && force_sel;
      tag_req   <= hit && !force_sel && cpu_opcode_fetch;
    end
  end
endmodule
`default_nettype wire

// file: logic/debug_consts.svh
`ifndef DEBUG_SCR_CONSTS_SVH
`define DEBUG_SCR_CONSTS_SVH
`define SCR_OFFSET        8'h00
`define SCR_BIT_PERMIT    7
`define SCR_BIT_HALT      6
`define SCR_BIT_BKPT_EN   5
`define SCR_BIT_FTS       4
`define SCR_BIT_CLKSEL    3
`define SCR_BIT_WS        2
`define SCR_RESET_NORMAL  8'h00
`define SCR_RESET_HALTED  8'hc8
`define SCR_WRITE_MASK    8'hb8
`endif

// file: logic/debug_pkg.sv
package debug_pkg;
  typedef enum logic [1:0] {
    cpu_run   = 2'b00,
    cpu_halt  = 2'b01,
    cpu_sleep = 2'b10
  } cpu_state_e;
endpackage

// file: logic/debug_status_control.sv
// Function
// - register reached only via serial commands
// - reset in halt: permit, halt, clksel one
// - permit bit gates entry to halt
// - permit holds until normal reset
// - halt flag read-only, set while halted
// - breakpoint disabled ignores select and address
// - force select: match forces halt at boundary
// - tag select: tagged opcode halts at execution
// - clock select: zero alternate, one bus
// - wait/stop flag reports sleeping cpu
// - halt command wakes sleeping cpu into halt
// - wait/stop flag stays after wake-to-halt
`timescale 1ns/1ns
`default_nettype none
`include "debug_consts.svh"
module debug_status_control
  import debug_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        reset_in_halt,
  input  wire logic        ctrl_write,
  input  wire logic [7:0]  ctrl_wdata,
  output logic [7:0]       status_rdata,
  input  wire logic        halt_cmd,
  input  wire logic [15:0] bkpt_addr,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_addr_valid,
  input  wire logic        cpu_opcode_fetch,
  input  wire logic        cpu_insn_boundary,
  input  wire logic        cpu_tag_exec,
  input  wire logic        cpu_sleep_enter,
  input  wire logic        cpu_resume,
  output logic             cpu_halt_req,
  output logic             cpu_wake_req,
  output logic             cpu_tag_mark,
  output logic             link_clock_select
);
  logic             debug_permit_q;
  logic             bkpt_en_q;
  logic             fts_q;
  logic             clksel_q;
  logic             ws_q;
  logic             strap_q;
  logic             strap_done_q;
  logic             force_pend_q;
  cpu_state_e       state_q;
  logic             force_req;
  logic             tag_req;
  logic             halt_enter;
  logic             halt_ok;
  logic             halted;
  logic [7:0]       wdata_masked;

  // reset words kept as vectors so single bits can be picked from them
  localparam logic [7:0] scr_reset_normal = `SCR_RESET_NORMAL;
  localparam logic [7:0] scr_reset_halted = `SCR_RESET_HALTED;
  localparam logic [7:0] scr_write_mask   = `SCR_WRITE_MASK;

  // halt decode shared by status read, cpu hold and pending force
  function automatic logic is_halted(input cpu_state_e st);
    return st == cpu_halt;
  endfunction

  // serial halt command counts only once the host permitted halt mode
  function automatic logic halt_permitted(input logic cmd, input logic permit);
    return cmd && permit;
  endfunction

  // status flag positions never taken from a write, whatever the host sends
  function automatic logic [7:0] writable_bits(input logic [7:0] wdata);
    return wdata & scr_write_mask;
  endfunction

  // decoded once here, read by several processes
  assign halted       = is_halted(state_q);
  assign halt_ok      = halt_permitted(halt_cmd, debug_permit_q);
  assign wdata_masked = writable_bits(ctrl_wdata);

  breakpoint_match u_match (
    .sys_clk          (sys_clk),
    .resetn           (resetn),
    .enable           (bkpt_en_q),
    .force_sel        (fts_q),
    .match_addr       (bkpt_addr),
    .cpu_addr         (cpu_addr),
    .cpu_addr_valid   (cpu_addr_valid),
    .cpu_opcode_fetch (cpu_opcode_fetch),
    .force_req        (force_req),
    .tag_req          (tag_req)
  );

  // halt-reset strap caught on first edge after release, not under reset
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strap_q      <= 1'b0;
      strap_done_q <= 1'b0;
    end
    else
    begin
      strap_done_q <= 1'b1;
      strap_q      <= !strap_done_q && reset_in_halt;
    end
  end

  // control bits; only the writable mask is taken from the host
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      debug_permit_q <= scr_reset_normal[`SCR_BIT_PERMIT];
      bkpt_en_q      <= scr_reset_normal[`SCR_BIT_BKPT_EN];
      fts_q          <= scr_reset_normal[`SCR_BIT_FTS];
      clksel_q       <= scr_reset_normal[`SCR_BIT_CLKSEL];
    end
    // strap beats a write in the same cycle; host is not talking yet
    else if (strap_q)
    begin
      debug_permit_q <= scr_reset_halted[`SCR_BIT_PERMIT];
      bkpt_en_q      <= scr_reset_halted[`SCR_BIT_BKPT_EN];
      fts_q          <= scr_reset_halted[`SCR_BIT_FTS];
      clksel_q       <= scr_reset_halted[`SCR_BIT_CLKSEL];
    end
    else if (ctrl_write)
    begin
      debug_permit_q <= debug_permit_q | wdata_masked[`SCR_BIT_PERMIT];
      bkpt_en_q      <= wdata_masked[`SCR_BIT_BKPT_EN];
      fts_q          <= wdata_masked[`SCR_BIT_FTS];
      clksel_q       <= wdata_masked[`SCR_BIT_CLKSEL];
    end
  end

  // force request waits for the instruction boundary
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      force_pend_q <= 1'b0;
    else if (force_req)
      force_pend_q <= 1'b1;
    // a disabled breakpoint also drops a force still waiting for its boundary
    else if (!bkpt_en_q || cpu_insn_boundary || halted)
      force_pend_q <= 1'b0;
  end

  // tagged opcode halts where the cpu reports it, no boundary wait
  assign halt_enter = debug_permit_q &&
    (((force_pend_q || force_req) && cpu_insn_boundary) || cpu_tag_exec);

  // cpu run/halt/sleep tracking; writes never touch this
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= cpu_run;
      ws_q    <= 1'b0;
    end
    else if (strap_q)
    begin
      state_q <= cpu_halt;
      ws_q    <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        cpu_run:
        begin
          if (halt_enter || halt_ok)
            state_q <= cpu_halt;
          else if (cpu_sleep_enter)
          begin
            state_q <= cpu_sleep;
            ws_q    <= 1'b1;
          end
        end
        cpu_sleep:
        begin
          // wait/stop flag kept so the host sees where the halt came from
          if (halt_ok)
            state_q <= cpu_halt;
          else if (cpu_resume)
          begin
            state_q <= cpu_run;
            ws_q    <= 1'b0;
          end
        end
        cpu_halt:
        begin
          if (cpu_resume)
          begin
            state_q <= cpu_run;
            ws_q    <= 1'b0;
          end
        end
        // unused code drops back to run instead of wedging the cpu
        default: state_q <= cpu_run;
      endcase
    end
  end

  // read path is flop outputs plus the halt decode of state_q, no read strobe needed
  always_comb
  begin
    status_rdata = 8'h00;
    status_rdata[`SCR_BIT_PERMIT]  = debug_permit_q;
    status_rdata[`SCR_BIT_HALT]    = halted;
    status_rdata[`SCR_BIT_BKPT_EN] = bkpt_en_q;
    status_rdata[`SCR_BIT_FTS]     = fts_q;
    status_rdata[`SCR_BIT_CLKSEL]  = clksel_q;
    status_rdata[`SCR_BIT_WS]      = ws_q;
  end

  assign cpu_halt_req      = halted;
  assign cpu_wake_req      = (state_q == cpu_sleep) && halt_ok;
  assign cpu_tag_mark      = tag_req && debug_permit_q;
  assign link_clock_select = clksel_q;
endmodule
`default_nettype wire

// file: verif/debug_host.sv
`timescale 1ns/1ns
`default_nettype none
module debug_host (
  input  wire logic       sys_clk,
  input  wire logic [7:0] status_rdata,
  output logic            ctrl_write = 1'b0,
  output logic [7:0]      ctrl_wdata = 8'h00,
  output logic            halt_cmd = 1'b0
);
  // data lines show the inverse once released so stale values never pass
  task wr(input logic [7:0] d);
    ctrl_write = 1'b1;
    ctrl_wdata = d;
    @(posedge sys_clk);
    #1 ctrl_write = 1'b0;
    ctrl_wdata = ~d;
  endtask
  task bg(output logic ok);
    halt_cmd = 1'b1;
    @(posedge sys_clk);
    #1 halt_cmd = 1'b0;
    ok = status_rdata[6];
  endtask
endmodule
`default_nettype wire

// file: verif/debug_status_control_props.sv
`timescale 1ns/1ns
`default_nettype none
module debug_status_control_props (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        reset_in_halt,
  input wire logic        ctrl_write,
  input wire logic        halt_cmd,
  input wire logic        cpu_resume,
  input wire logic        cpu_addr_valid,
  input wire logic        cpu_opcode_fetch,
  input wire logic        cpu_sleep_enter,
  input wire logic        cpu_insn_boundary,
  input wire logic        cpu_tag_exec,
  input wire logic        cpu_halt_req,
  input wire logic        cpu_wake_req,
  input wire logic        cpu_tag_mark,
  input wire logic        link_clock_select,
  input wire logic [7:0]  ctrl_wdata,
  input wire logic [7:0]  status_rdata,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] bkpt_addr
);
  wire [7:0] s = status_rdata;
  // other halt or sleep causes would move the flags legitimately
  wire quiet = !(halt_cmd || cpu_resume || cpu_sleep_enter || cpu_insn_boundary || cpu_tag_exec);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_keep; (s[7] || (ctrl_write && ctrl_wdata[7])) |=> s[7]; endproperty
  property p_ro; ctrl_write && quiet |=> $stable({s[6], s[2]}); endproperty
  property p_wr; ctrl_write |=> s[5:3] == $past(ctrl_wdata[5:3]); endproperty
  property p_clk; link_clock_select == s[3]; endproperty
  property p_gate; !s[7] && !cpu_halt_req && !reset_in_halt |=> !cpu_halt_req; endproperty
  property p_flag; s[6] == cpu_halt_req; endproperty
  property p_hcmd; halt_cmd && s[7] && !cpu_resume |=> s[6] && $stable(s[2]); endproperty
  property p_ws; cpu_sleep_enter && !s[6] && !halt_cmd && !cpu_insn_boundary && !cpu_tag_exec
    && !cpu_resume |=> s[2]; endproperty
  property p_tag; cpu_opcode_fetch && cpu_addr_valid && cpu_addr == bkpt_addr && s[7] && s[5]
    && !s[4] |=> cpu_tag_mark; endproperty
  property p_dis; !s[5] |=> !cpu_tag_mark; endproperty
  a_keep: assert property (p_keep) else $error("permit bit dropped");
  a_ro: assert property (p_ro) else $error("write moved a status flag");
  a_wr: assert property (p_wr) else $error("control bits not written");
  a_clk: assert property (p_clk) else $error("link clock select mismatch");
  a_gate: assert property (p_gate) else $error("halt without permit");
  a_flag: assert property (p_flag) else $error("halt flag wrong");
  a_hcmd: assert property (p_hcmd) else $error("halt command ignored");
  a_ws: assert property (p_ws) else $error("wait flag not set");
  a_tag: assert property (p_tag) else $error("opcode not tagged");
  a_dis: assert property (p_dis) else $error("tag while disabled");
  c_halt: cover property (halt_cmd ##1 s[6]);
  c_wake: cover property (cpu_wake_req);
  c_tag: cover property (cpu_tag_mark);
endmodule
bind debug_status_control debug_status_control_props props (
  .sys_clk           (sys_clk),
  .resetn            (resetn),
  .reset_in_halt     (reset_in_halt),
  .ctrl_write        (ctrl_write),
  .halt_cmd          (halt_cmd),
  .cpu_resume        (cpu_resume),
  .cpu_addr_valid    (cpu_addr_valid),
  .cpu_opcode_fetch  (cpu_opcode_fetch),
  .cpu_sleep_enter   (cpu_sleep_enter),
  .cpu_insn_boundary (cpu_insn_boundary),
  .cpu_tag_exec      (cpu_tag_exec),
  .cpu_halt_req      (cpu_halt_req),
  .cpu_wake_req      (cpu_wake_req),
  .cpu_tag_mark      (cpu_tag_mark),
  .link_clock_select (link_clock_select),
  .ctrl_wdata        (ctrl_wdata),
  .status_rdata      (status_rdata),
  .cpu_addr          (cpu_addr),
  .bkpt_addr         (bkpt_addr)
);
`default_nettype wire

// file: verif/debug_status_control_test.sv
`timescale 1ns/1ns
`default_nettype none
module debug_status_control_test;
  logic sys_clk = 1'b0, resetn, reset_in_halt, ctrl_write, halt_cmd, cpu_addr_valid, ok;
  logic cpu_opcode_fetch, cpu_insn_boundary, cpu_tag_exec, cpu_sleep_enter, cpu_resume;
  logic cpu_halt_req, cpu_wake_req, cpu_tag_mark, link_clock_select;
  logic [7:0] ctrl_wdata, status_rdata, cf [3] = '{8'h90, 8'hb0, 8'ha0};
  logic [15:0] bkpt_addr, cpu_addr;
  logic [7:0] wake_cnt = 8'h00;
  wire [7:0] s = status_rdata;
  int err_total = 0, num_checks = 0, cyc = 0;
  debug_status_control dut (
    .sys_clk           (sys_clk),
    .resetn            (resetn),
    .reset_in_halt     (reset_in_halt),
    .ctrl_write        (ctrl_write),
    .ctrl_wdata        (ctrl_wdata),
    .status_rdata      (status_rdata),
    .halt_cmd          (halt_cmd),
    .bkpt_addr         (bkpt_addr),
    .cpu_addr          (cpu_addr),
    .cpu_addr_valid    (cpu_addr_valid),
    .cpu_opcode_fetch  (cpu_opcode_fetch),
    .cpu_insn_boundary (cpu_insn_boundary),
    .cpu_tag_exec      (cpu_tag_exec),
    .cpu_sleep_enter   (cpu_sleep_enter),
    .cpu_resume        (cpu_resume),
    .cpu_halt_req      (cpu_halt_req),
    .cpu_wake_req      (cpu_wake_req),
    .cpu_tag_mark      (cpu_tag_mark),
    .link_clock_select (link_clock_select)
  );
  debug_host h (
    .sys_clk      (sys_clk),
    .status_rdata (status_rdata),
    .ctrl_write   (ctrl_write),
    .ctrl_wdata   (ctrl_wdata),
    .halt_cmd     (halt_cmd)
  );
  always #10 sys_clk = ~sys_clk;
  // wake pulse is combinational; count it mid-cycle where it has settled
  always @(negedge sys_clk)
    if (cpu_wake_req)
      wake_cnt <= wake_cnt + 8'h01;
  task tk;
    @(posedge sys_clk);
    #1;
  endtask
  task chk(input string n, input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge sys_clk)
    if (++cyc > 500)
    begin
      err_total++;
      report_and_stop;
    end
  initial
  begin
    {resetn, reset_in_halt, cpu_addr_valid, cpu_opcode_fetch, cpu_insn_boundary} = '0;
    {cpu_tag_exec, cpu_sleep_enter, cpu_resume} = '0;
    bkpt_addr = 16'h1234;
    cpu_addr = 16'h0000;
    repeat (4) @(posedge sys_clk);
    #1 resetn = 1'b1;
    tk;
    tk;
    chk("reset", s, 8'h00);
    h.bg(ok);
    chk("deny", {7'h0, ok}, 8'h00);
    h.wr(8'hff);
    chk("write", s, 8'hb8);
    chk("clksel", {7'h0, link_clock_select}, 8'h01);
    tk;
    h.wr(8'h00);
    chk("permit", s, 8'h80);
    h.bg(ok);
    chk("halt", {6'h0, ok, cpu_halt_req}, 8'h03);
    $display("test registers done");
    foreach (cf[i])
    begin
      cpu_resume = 1'b1;
      tk;
      cpu_resume = 1'b0;
      h.wr(cf[i]);
      {cpu_addr, cpu_addr_valid, cpu_opcode_fetch} = {16'h1234, 2'b11};
      tk;
      {cpu_addr_valid, cpu_opcode_fetch} = 2'b00;
      chk("mark", {7'h0, cpu_tag_mark}, {7'h0, cf[i][5] & ~cf[i][4]});
      {cpu_insn_boundary, cpu_tag_exec} = {1'b1, cf[i][5] & ~cf[i][4]};
      tk;
      {cpu_insn_boundary, cpu_tag_exec} = 2'b00;
      repeat (3) tk;
      chk("break", {7'h0, cpu_halt_req}, {7'h0, cf[i][5]});
    end
    $display("test breakpoint done");
    cpu_resume = 1'b1;
    tk;
    {cpu_resume, cpu_sleep_enter} = 2'b01;
    tk;
    cpu_sleep_enter = 1'b0;
    chk("sleep", s, 8'ha4);
    h.bg(ok);
    chk("wake", s, 8'he4);
    h.wr(8'h00);
    chk("flags", s, 8'hc4);
    resetn = 1'b0;
    reset_in_halt = 1'b1;
    tk;
    resetn = 1'b1;
    tk;
    tk;
    reset_in_halt = 1'b0;
    chk("halt reset", s, 8'hc8);
    chk("wake req", wake_cnt, 8'h01);
    $display("test sleep and reset done");
    report_and_stop;
  end
endmodule
`default_nettype wire
